/* rtl/vmr_pkg.sv */
// Purpose: shared constants and types for the vendor mode register bank
// Assumes: 25 MHz system clock, 16-bit management registers
// Notes:   register offsets are management register indices
package vmr_pkg;

    // ------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------
    localparam logic [4:0] MODE_CONTROL_STATUS_IDX        = 5'h11;
    localparam logic [4:0] SPECIAL_MODES_IDX              = 5'h12;
    localparam logic [4:0] SYMBOL_ERROR_COUNTER_IDX       = 5'h1a;
    localparam logic [4:0] CROSSOVER_POLARITY_CONTROL_IDX = 5'h1b;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int EDPD_BIT          = 13;
    localparam int LOOPBACK_BIT      = 9;
    localparam int ALT_IRQ_BIT       = 6;
    localparam int ENERGY_BIT        = 1;
    localparam int MCS_SPARE_BIT     = 0;
    localparam int HOST_IF_BIT       = 14;
    localparam int OP_MODE_LSB       = 5;
    localparam int STATION_ADDR_LSB  = 0;
    localparam int AUTO_XOVER_DIS_BIT = 15;
    localparam int PAIR_SELECT_BIT   = 13;
    localparam int POLARITY_BIT      = 4;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic        ENERGY_PRESENT_RST = 1'b1;
    localparam logic [15:0] SYMBOL_ERROR_RST   = 16'h0000;
    localparam logic [15:0] READ_UNMAPPED      = 16'h0000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ           = 25_000_000;
    localparam int ENERGY_WINDOW_MS = 256;
    localparam int ENERGY_WINDOW_CYCLES = (CLK_HZ / 1000) * ENERGY_WINDOW_MS;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  phy;
        logic [4:0]  idx;
        logic [15:0] wdata;
    } vmr_mgmt_req_t;

endpackage

/* rtl/vmr_regs.sv */
// Purpose: vendor mode/status register bank of a 10/100 transceiver
// Assumes: management frames already decoded into one-cycle requests
// Notes:   soft_reset_i is a one-cycle pulse from the control register
`timescale 1ns/1ps
module vmr_regs
    import vmr_pkg::*;
#(
    parameter int ENERGY_WINDOW = vmr_pkg::ENERGY_WINDOW_CYCLES
) (
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  ce_i,
    input  wire logic                  soft_reset_i,
    input  wire vmr_pkg::vmr_mgmt_req_t mgmt_req_i,
    output logic [15:0]                mgmt_rdata_o,
    output logic                       mgmt_rvalid_o,
    input  wire logic [2:0]            mode_strap_i,
    input  wire logic [2:0]            addr_strap_i,
    input  wire logic                  speed_100_i,
    input  wire logic                  energy_seen_i,
    input  wire logic                  rx_symbol_invalid_i,
    input  wire logic                  rx_packet_active_i,
    input  wire logic                  rx_polarity_reversed_i,
    input  wire logic                  auto_mdix_i,
    output logic                       energy_detect_powerdown_enable_o,
    output logic                       alternate_irq_scheme_select_o,
    output logic                       line_side_loopback_active_o,
    output logic                       line_energy_present_o,
    output logic                       host_interface_select_o,
    output logic [2:0]                 operating_mode_o,
    output logic [4:0]                 station_address_o,
    output logic [4:0]                 scrambler_seed_o,
    output logic                       auto_crossover_enable_o,
    output logic                       mdix_select_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic        edpd_r, edpd_nxt;
    logic        loopback_r, loopback_nxt;
    logic        alt_irq_r, alt_irq_nxt;
    logic        mcs_spare_r, mcs_spare_nxt;
    logic        energy_r, energy_nxt;
    logic [22:0] silence_r, silence_nxt;
    logic        host_if_r, host_if_nxt;
    logic [2:0]  op_mode_r, op_mode_nxt;
    logic [4:0]  station_r, station_nxt;
    logic        straps_done_r, straps_done_nxt;
    logic [15:0] sym_cnt_r, sym_cnt_nxt;
    logic        pkt_counted_r, pkt_counted_nxt;
    logic        xover_dis_r, xover_dis_nxt;
    logic        pair_sel_r, pair_sel_nxt;
    logic        polarity_r, polarity_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic        rvalid_r, rvalid_nxt;

    logic        addr_hit;
    logic        wr_hit;
    logic        sym_inc;

    // ------------------------------------------------------------
    // management access
    // ------------------------------------------------------------
    assign addr_hit = mgmt_req_i.phy == station_r;
    assign wr_hit   = mgmt_req_i.wr && addr_hit && straps_done_r;

    // one count per packet; outside a packet every idle error counts at 100 Mb/s
    assign sym_inc = speed_100_i && rx_symbol_invalid_i
                     && !(rx_packet_active_i && pkt_counted_r);

    always_comb begin
        edpd_nxt        = edpd_r;
        loopback_nxt    = loopback_r;
        alt_irq_nxt     = alt_irq_r;
        mcs_spare_nxt   = mcs_spare_r;
        host_if_nxt     = host_if_r;
        op_mode_nxt     = op_mode_r;
        station_nxt     = station_r;
        straps_done_nxt = 1'b1;
        xover_dis_nxt   = xover_dis_r;
        pair_sel_nxt    = pair_sel_r;
        // straps caught on the first enabled edge after release
        if (!straps_done_r) begin
            op_mode_nxt = mode_strap_i;
            station_nxt = {2'b00, addr_strap_i};
        end else if (soft_reset_i) begin
            // strap-derived fields are kept on purpose
            edpd_nxt      = 1'b0;
            loopback_nxt  = 1'b0;
            alt_irq_nxt   = 1'b0;
            mcs_spare_nxt = 1'b0;
            xover_dis_nxt = 1'b0;
            pair_sel_nxt  = 1'b0;
        end else if (wr_hit) begin
            unique case (mgmt_req_i.idx)
                MODE_CONTROL_STATUS_IDX: begin
                    edpd_nxt      = mgmt_req_i.wdata[EDPD_BIT];
                    loopback_nxt  = mgmt_req_i.wdata[LOOPBACK_BIT];
                    alt_irq_nxt   = mgmt_req_i.wdata[ALT_IRQ_BIT];
                    mcs_spare_nxt = mgmt_req_i.wdata[MCS_SPARE_BIT];
                end
                SPECIAL_MODES_IDX: begin
                    host_if_nxt = mgmt_req_i.wdata[HOST_IF_BIT];
                    op_mode_nxt = mgmt_req_i.wdata[OP_MODE_LSB +: 3];
                    station_nxt = mgmt_req_i.wdata[STATION_ADDR_LSB +: 5];
                end
                CROSSOVER_POLARITY_CONTROL_IDX: begin
                    xover_dis_nxt = mgmt_req_i.wdata[AUTO_XOVER_DIS_BIT];
                    pair_sel_nxt  = mgmt_req_i.wdata[PAIR_SELECT_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // status: energy, symbol errors, polarity
    // ------------------------------------------------------------
    always_comb begin
        energy_nxt  = energy_r;
        silence_nxt = silence_r;
        if (energy_seen_i) begin
            energy_nxt  = 1'b1;
            silence_nxt = '0;
        end else if (silence_r >= 23'(ENERGY_WINDOW - 1)) begin
            energy_nxt = 1'b0;
        end else begin
            silence_nxt = silence_r + 23'd1;
        end
        // soft reset deliberately leaves the energy flag alone
        sym_cnt_nxt     = sym_inc ? sym_cnt_r + 16'd1 : sym_cnt_r;
        pkt_counted_nxt = rx_packet_active_i && (pkt_counted_r || sym_inc);
        if (soft_reset_i) begin
            sym_cnt_nxt     = SYMBOL_ERROR_RST;
            pkt_counted_nxt = 1'b0;
        end
        polarity_nxt = rx_polarity_reversed_i;
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        rdata_nxt  = rdata_r;
        rvalid_nxt = mgmt_req_i.rd && addr_hit && straps_done_r;
        if (rvalid_nxt) begin
            rdata_nxt = READ_UNMAPPED;
            unique case (mgmt_req_i.idx)
                MODE_CONTROL_STATUS_IDX: begin
                    rdata_nxt[EDPD_BIT]      = edpd_r;
                    rdata_nxt[LOOPBACK_BIT]  = loopback_r;
                    rdata_nxt[ALT_IRQ_BIT]   = alt_irq_r;
                    rdata_nxt[ENERGY_BIT]    = energy_r;
                    rdata_nxt[MCS_SPARE_BIT] = mcs_spare_r;
                end
                SPECIAL_MODES_IDX: begin
                    rdata_nxt[HOST_IF_BIT]             = host_if_r;
                    rdata_nxt[OP_MODE_LSB +: 3]        = op_mode_r;
                    rdata_nxt[STATION_ADDR_LSB +: 5]   = station_r;
                end
                SYMBOL_ERROR_COUNTER_IDX: begin
                    rdata_nxt = sym_cnt_r;
                end
                CROSSOVER_POLARITY_CONTROL_IDX: begin
                    rdata_nxt[AUTO_XOVER_DIS_BIT] = xover_dis_r;
                    rdata_nxt[PAIR_SELECT_BIT]    = pair_sel_r;
                    rdata_nxt[POLARITY_BIT]       = polarity_r;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            edpd_r        <= 1'b0;
            loopback_r    <= 1'b0;
            alt_irq_r     <= 1'b0;
            mcs_spare_r   <= 1'b0;
            energy_r      <= ENERGY_PRESENT_RST;
            silence_r     <= '0;
            host_if_r     <= 1'b0;
            op_mode_r     <= '0;
            station_r     <= '0;
            straps_done_r <= 1'b0;
            sym_cnt_r     <= SYMBOL_ERROR_RST;
            pkt_counted_r <= 1'b0;
            xover_dis_r   <= 1'b0;
            pair_sel_r    <= 1'b0;
            polarity_r    <= 1'b0;
            rdata_r       <= '0;
            rvalid_r      <= 1'b0;
        end else if (ce_i) begin
            edpd_r        <= edpd_nxt;
            loopback_r    <= loopback_nxt;
            alt_irq_r     <= alt_irq_nxt;
            mcs_spare_r   <= mcs_spare_nxt;
            energy_r      <= energy_nxt;
            silence_r     <= silence_nxt;
            host_if_r     <= host_if_nxt;
            op_mode_r     <= op_mode_nxt;
            station_r     <= station_nxt;
            straps_done_r <= straps_done_nxt;
            sym_cnt_r     <= sym_cnt_nxt;
            pkt_counted_r <= pkt_counted_nxt;
            xover_dis_r   <= xover_dis_nxt;
            pair_sel_r    <= pair_sel_nxt;
            polarity_r    <= polarity_nxt;
            rdata_r       <= rdata_nxt;
            rvalid_r      <= rvalid_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign mgmt_rdata_o                     = rdata_r;
    assign mgmt_rvalid_o                    = rvalid_r && ce_i;
    assign energy_detect_powerdown_enable_o = edpd_r;
    assign alternate_irq_scheme_select_o    = alt_irq_r;
    // isolate does not gate this path
    assign line_side_loopback_active_o = loopback_r && host_if_r && speed_100_i;
    assign line_energy_present_o            = energy_r;
    assign host_interface_select_o          = host_if_r;
    assign operating_mode_o                 = op_mode_r;
    assign station_address_o                = station_r;
    assign scrambler_seed_o                 = station_r;
    assign auto_crossover_enable_o          = !xover_dis_r;
    assign mdix_select_o = xover_dis_r ? pair_sel_r : auto_mdix_i;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    AST_EDPD_WRITE: assert property (
        ce_i && straps_done_r && !soft_reset_i && mgmt_req_i.wr && addr_hit
        && mgmt_req_i.idx == MODE_CONTROL_STATUS_IDX
        |=> energy_detect_powerdown_enable_o == $past(mgmt_req_i.wdata[EDPD_BIT]))
        else $error("power-down enable did not follow write");
    AST_LOOPBACK_GATE: assert property (
        line_side_loopback_active_o |-> host_interface_select_o && speed_100_i)
        else $error("loopback active outside rmii 100 mode");
    AST_ENERGY_DROP: assert property (
        ce_i && !energy_seen_i && silence_r >= 23'(ENERGY_WINDOW - 1)
        |=> !line_energy_present_o)
        else $error("energy flag did not drop after window");
    AST_ENERGY_SOFT: assert property (
        ce_i && soft_reset_i && !energy_seen_i && silence_r == '0 && energy_r
        |=> line_energy_present_o)
        else $error("soft reset changed energy flag");
    AST_STRAP_KEEP: assert property (
        ce_i && straps_done_r && soft_reset_i
        |=> $stable(station_address_o) && $stable(operating_mode_o)
            && $stable(host_interface_select_o))
        else $error("strap fields lost on soft reset");
    AST_COUNT_10: assert property (
        !speed_100_i && !soft_reset_i |=> $stable(sym_cnt_r))
        else $error("symbol counter moved in 10 mode");
    AST_ONCE_PER_PKT: assert property (
        ce_i && rx_packet_active_i && pkt_counted_r && !soft_reset_i
        |=> $stable(sym_cnt_r))
        else $error("second count within one packet");
    AST_WRAP: assert property (
        ce_i && sym_inc && !soft_reset_i && sym_cnt_r == 16'hffff
        |=> sym_cnt_r == 16'h0000)
        else $error("symbol counter did not wrap");
    AST_READ_KEEPS: assert property (
        ce_i && !sym_inc && !soft_reset_i |=> $stable(sym_cnt_r))
        else $error("symbol counter changed without an error");
    AST_MANUAL_PAIR: assert property (
        !auto_crossover_enable_o |-> mdix_select_o == pair_sel_r)
        else $error("manual pair select ignored");

    COV_COUNT: cover property (ce_i && sym_inc);
    COV_LOOPBACK: cover property (line_side_loopback_active_o);
    COV_ENERGY_LOST: cover property (line_energy_present_o ##1 !line_energy_present_o);
    COV_READ_CNT: cover property (
        mgmt_rvalid_o && $past(mgmt_req_i.idx) == SYMBOL_ERROR_COUNTER_IDX);

endmodule

/* bench/vmr_mgmt_host.sv */
// Purpose: management station model issuing decoded register requests
// Assumes: one-cycle request pulses, read answer within three cycles
// Notes:   requests change only just after a rising edge
`timescale 1ns/1ps
module vmr_mgmt_host
    import vmr_pkg::*;
(
    input  wire logic                   clk_sys_i,
    input  wire logic [15:0]            mgmt_rdata_i,
    input  wire logic                   mgmt_rvalid_i,
    output vmr_pkg::vmr_mgmt_req_t      mgmt_req_o
);
    initial mgmt_req_o = '0;

    // ------------------------------------------------------------
    // request tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [4:0] phy, input logic [4:0] idx, input logic [15:0] d);
        @(posedge clk_sys_i);
        mgmt_req_o <= {1'b1, 1'b0, phy, idx, d};
        @(posedge clk_sys_i);
        mgmt_req_o <= '0;
    endtask

    // ok stays low when the request was refused
    task automatic rd(input logic [4:0] phy, input logic [4:0] idx,
                      output logic [15:0] d, output logic ok);
        ok = 1'b0;
        d = 16'h0000;
        @(posedge clk_sys_i);
        mgmt_req_o <= {1'b0, 1'b1, phy, idx, 16'h0000};
        @(posedge clk_sys_i);
        mgmt_req_o <= '0;
        for (int i = 0; i < 3 && !ok; i++) begin
            #1;
            if (mgmt_rvalid_i === 1'b1) begin
                ok = 1'b1;
                d = mgmt_rdata_i;
            end else begin
                @(posedge clk_sys_i);
            end
        end
    endtask
endmodule

/* bench/tb_top.sv */
// Purpose: self-checking bench for the vendor mode register bank
// Assumes: short energy window, straps mode 101 and address 011
// Notes:   counter wrap test runs about 65k cycles
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin num_errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end
module tb_top;
    import vmr_pkg::*;
    localparam int WIN = 16;
    logic clk_sys_i = 1'b0, rst_n_i = 1'b0, soft_reset = 1'b0, speed_100 = 1'b1;
    logic energy_seen = 1'b1, sym_inv = 1'b0, pkt_act = 1'b0, pol_rev = 1'b0, auto_mdix = 1'b0;
    logic [2:0]     mode_strap = 3'b101, addr_strap = 3'b011, op_mode;
    logic [4:0]     st_addr, seed, pa = 5'h03;
    logic [15:0]    rdata;
    logic           rvalid, edpd, alt_irq, loop_act, energy, host_if, xover_en, mdix;
    logic           ce = 1'b1;
    vmr_mgmt_req_t  req;
    int             num_errors = 0, n_compared = 0;

    always #20 clk_sys_i = ~clk_sys_i;

    vmr_mgmt_host i_host (.clk_sys_i(clk_sys_i), .mgmt_rdata_i(rdata),
        .mgmt_rvalid_i(rvalid), .mgmt_req_o(req));

    vmr_regs #(.ENERGY_WINDOW(WIN)) i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .ce_i(ce), .soft_reset_i(soft_reset), .mgmt_req_i(req), .mgmt_rdata_o(rdata),
        .mgmt_rvalid_o(rvalid), .mode_strap_i(mode_strap), .addr_strap_i(addr_strap),
        .speed_100_i(speed_100), .energy_seen_i(energy_seen), .rx_symbol_invalid_i(sym_inv),
        .rx_packet_active_i(pkt_act), .rx_polarity_reversed_i(pol_rev),
        .auto_mdix_i(auto_mdix), .energy_detect_powerdown_enable_o(edpd),
        .alternate_irq_scheme_select_o(alt_irq), .line_side_loopback_active_o(loop_act),
        .line_energy_present_o(energy), .host_interface_select_o(host_if),
        .operating_mode_o(op_mode), .station_address_o(st_addr), .scrambler_seed_o(seed),
        .auto_crossover_enable_o(xover_en), .mdix_select_o(mdix));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic rchk(string nm, logic [4:0] phy, logic [4:0] idx, logic [16:0] ex);
        logic [15:0] d;
        logic ok;
        i_host.rd(phy, idx, d, ok);
        `CHK(nm, ex, {ok, d})
    endtask

    // holds the invalid-symbol input for n sampling edges
    task automatic sym(int n);
        @(posedge clk_sys_i);
        sym_inv <= 1'b1;
        repeat (n) @(posedge clk_sys_i);
        sym_inv <= 1'b0;
    endtask

    task automatic hw_reset();
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        `CHK("edpd", 1'b0, edpd);
        `CHK("alt_irq", 1'b0, alt_irq);
        `CHK("energy", 1'b1, energy);
        `CHK("host_if", 1'b0, host_if);
        `CHK("op_mode", 3'b101, op_mode);
        `CHK("seed", 5'h03, seed);
        `CHK("st_addr", 5'h03, st_addr);
        rchk("reg17", pa, MODE_CONTROL_STATUS_IDX, {1'b1, 16'h0002});
        rchk("reg18", pa, SPECIAL_MODES_IDX, {1'b1, 16'h00A3});
        rchk("reg26", pa, SYMBOL_ERROR_COUNTER_IDX, {1'b1, 16'h0000});
        rchk("reg27", pa, CROSSOVER_POLARITY_CONTROL_IDX, {1'b1, 16'h0000});
        rchk("unmapped", pa, 5'h05, {1'b1, 16'h0000});
    endtask

    task automatic t_modes();
        i_host.wr(pa, MODE_CONTROL_STATUS_IDX, 16'hFFFF);
        #1;
        `CHK("edpd on", 1'b1, edpd);
        `CHK("alt on", 1'b1, alt_irq);
        `CHK("loop mii", 1'b0, loop_act);
        rchk("reg17 rw", pa, MODE_CONTROL_STATUS_IDX, {1'b1, 16'h2243});
        i_host.wr(pa, SPECIAL_MODES_IDX, 16'h40A3);
        #1;
        `CHK("loop rmii", 1'b1, loop_act);
        @(posedge clk_sys_i);
        speed_100 <= 1'b0;
        #1;
        `CHK("loop 10m", 1'b0, loop_act);
        @(posedge clk_sys_i);
        speed_100 <= 1'b1;
        i_host.wr(pa, CROSSOVER_POLARITY_CONTROL_IDX, 16'hFFFF);
        #1;
        `CHK("xover off", 1'b0, xover_en);
        `CHK("mdix man", 1'b1, mdix);
        rchk("reg27 rw", pa, CROSSOVER_POLARITY_CONTROL_IDX, {1'b1, 16'hA000});
        @(posedge clk_sys_i);
        auto_mdix <= 1'b1;
        i_host.wr(pa, CROSSOVER_POLARITY_CONTROL_IDX, 16'h8000);
        #1;
        `CHK("mdi man", 1'b0, mdix);
        i_host.wr(pa, CROSSOVER_POLARITY_CONTROL_IDX, 16'h0000);
        #1;
        `CHK("xover on", 1'b1, xover_en);
        `CHK("mdix auto", 1'b1, mdix);
        i_host.wr(pa, SPECIAL_MODES_IDX, 16'h40A7);
        rchk("old addr", pa, SPECIAL_MODES_IDX, {1'b0, 16'h0000});
        pa = 5'h07;
        rchk("new addr", pa, SPECIAL_MODES_IDX, {1'b1, 16'h40A7});
        `CHK("seed new", 5'h07, seed);
    endtask

    task automatic t_counter();
        sym(3);
        rchk("idle errs", pa, SYMBOL_ERROR_COUNTER_IDX, {1'b1, 16'h0003});
        @(posedge clk_sys_i);
        pkt_act <= 1'b1;
        repeat (3) sym(1);
        @(posedge clk_sys_i);
        pkt_act <= 1'b0;
        @(posedge clk_sys_i);
        speed_100 <= 1'b0;
        sym(5);
        @(posedge clk_sys_i);
        speed_100 <= 1'b1;
        rchk("pkt once", pa, SYMBOL_ERROR_COUNTER_IDX, {1'b1, 16'h0004});
        rchk("read keep", pa, SYMBOL_ERROR_COUNTER_IDX, {1'b1, 16'h0004});
        // errors while the enable is low must not count
        @(posedge clk_sys_i);
        ce <= 1'b0;
        sym(4);
        @(posedge clk_sys_i);
        ce <= 1'b1;
        rchk("ce frozen", pa, SYMBOL_ERROR_COUNTER_IDX, {1'b1, 16'h0004});
        sym(65531);
        rchk("count max", pa, SYMBOL_ERROR_COUNTER_IDX, {1'b1, 16'hFFFF});
        sym(1);
        rchk("count wrap", pa, SYMBOL_ERROR_COUNTER_IDX, {1'b1, 16'h0000});
        @(posedge clk_sys_i);
        pol_rev <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rchk("polarity", pa, CROSSOVER_POLARITY_CONTROL_IDX, {1'b1, 16'h0010});
    endtask

    task automatic t_energy();
        // soft reset while the flag is still set must keep it set
        @(posedge clk_sys_i);
        energy_seen <= 1'b0;
        soft_reset  <= 1'b1;
        @(posedge clk_sys_i);
        soft_reset <= 1'b0;
        repeat (7) @(posedge clk_sys_i);
        #1;
        `CHK("energy early", 1'b1, energy);
        repeat (WIN) @(posedge clk_sys_i);
        #1;
        `CHK("energy gone", 1'b0, energy);
        @(posedge clk_sys_i);
        soft_reset <= 1'b1;
        @(posedge clk_sys_i);
        soft_reset <= 1'b0;
        #1;
        `CHK("soft energy", 1'b0, energy);
        rchk("soft reg17", pa, MODE_CONTROL_STATUS_IDX, {1'b1, 16'h0000});
        rchk("soft reg18", pa, SPECIAL_MODES_IDX, {1'b1, 16'h40A7});
        @(posedge clk_sys_i);
        energy_seen <= 1'b1;
        hw_reset();
        pa = 5'h03;
        `CHK("hw energy", 1'b1, energy);
        rchk("hw reg18", pa, SPECIAL_MODES_IDX, {1'b1, 16'h00A3});
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        #1;
        t_reset();
        t_modes();
        t_counter();
        t_energy();
        wrap_up();
    end

    // the wrap test dominates the run at about 66k cycles
    initial begin
        repeat (100000) @(posedge clk_sys_i);
        num_errors++;
        wrap_up();
    end
endmodule
